// File: design/qdr_pkg.sv
// shared constants and types for the quad converter register decode
// assumes one 125 MHz system clock and 24-bit write frames from a serial host
package qdr_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CHANS = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LEN = 5'h18;

    // register select codes in frame bits 20..18
    localparam logic [2:0] SEL_DAC_DATA = 3'h0;
    localparam logic [2:0] SEL_GAIN = 3'h2;
    localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
    localparam logic [2:0] SEL_OFFSET = 3'h4;
    localparam logic [2:0] SEL_OFFSET_ALL = 3'h5;
    localparam logic [2:0] SEL_CLEAR_VALUE = 3'h6;
    localparam logic [2:0] SEL_CONTROL = 3'h7;

    // control selector codes in data bits 15..13
    localparam logic [2:0] CSEL_SLEW = 3'h0;
    localparam logic [2:0] CSEL_MAIN = 3'h1;
    localparam logic [2:0] CSEL_DAC_CTRL = 3'h2;
    localparam logic [2:0] CSEL_BOOST = 3'h3;
    localparam logic [2:0] CSEL_SOFTWARE = 3'h4;

    // field positions inside the 16-bit data field
    localparam int CSEL_HI = 15;
    localparam int CSEL_LO = 13;
    localparam int MC_STATUS_READ = 11;
    localparam int MC_WD_ENABLE = 10;
    localparam int MC_WD_PERIOD_HI = 9;
    localparam int MC_WD_PERIOD_LO = 8;
    localparam int MC_OUTPUT_ALL = 5;
    localparam int MC_BOOST_ALL = 4;
    localparam int DC_CLEAR_ENABLE = 7;

    // reset values
    localparam logic [15:0] GAIN_RST = 16'hffff;
    localparam logic [15:0] OFFSET_RST = 16'h8000;
    localparam logic [15:0] CLEAR_VALUE_RST = 16'h0000;
    localparam logic [15:0] DAC_DATA_RST = 16'h0000;

    // watchdog timeouts in ms and their cycle counts at the system clock
    localparam int CLK_KHZ = 125000;
    localparam int WD_T0_MS = 5;
    localparam int WD_T1_MS = 10;
    localparam int WD_T2_MS = 100;
    localparam int WD_T3_MS = 200;
    localparam int WD_T0_CYC = WD_T0_MS * CLK_KHZ;
    localparam int WD_T1_CYC = WD_T1_MS * CLK_KHZ;
    localparam int WD_T2_CYC = WD_T2_MS * CLK_KHZ;
    localparam int WD_T3_CYC = WD_T3_MS * CLK_KHZ;
    localparam int WD_W = 25;

    typedef struct packed {
        logic rw;
        logic [1:0] device_addr;
        logic [2:0] register_select;
        logic [1:0] channel_sel;
        logic [15:0] data;
    } qdr_frame_t;

    typedef struct packed {
        logic [15:0] dac_data;
        logic [15:0] gain;
        logic [15:0] offset;
        logic [15:0] clear_value;
        logic clear_enable;
    } qdr_chan_t;

    typedef struct packed {
        logic status_readback_enable;
        logic watchdog_enable;
        logic [1:0] watchdog_period;
        logic global_output_enable;
        logic global_boost_power_up;
    } qdr_main_t;

    typedef enum logic {
        LK_IDLE = 1'b0,
        LK_SHIFT = 1'b1
    } qdr_link_state_t;
endpackage

// File: design/qdr_pin_sync.sv
// three-stage pin synchroniser with an agreement filter
// assumes the pins are asynchronous to mclk; output moves once stages two and three agree
`timescale 1ns/1ps
module qdr_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // first stage feeds only the second, to contain metastability
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            meta <= pin;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // per bit: accept a change only when two settled stages agree
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            level <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end
endmodule

// File: design/qdr_chan_slot.sv
// storage for one converter channel: data, gain, offset, clear value and clear enable
// assumes write strobes are single-cycle and already decoded for this channel
`timescale 1ns/1ps
module qdr_chan_slot
    import qdr_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] wr_value,
    input wire logic wr_dac_data,
    input wire logic wr_gain,
    input wire logic wr_offset,
    input wire logic wr_clear_value,
    input wire logic wr_clear_enable,
    input wire logic clear_evt,
    output qdr_chan_t slot
);
    // data word: clear event beats a same-cycle write so the clear is never lost
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            slot.dac_data <= DAC_DATA_RST;
        end else if (clear_evt && slot.clear_enable) begin
            slot.dac_data <= slot.clear_value;
        end else if (wr_dac_data) begin
            slot.dac_data <= wr_value;
        end
    end

    // trim words, full straight-binary range, no clamping of gain
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            slot.gain <= GAIN_RST;
            slot.offset <= OFFSET_RST;
        end else begin
            if (wr_gain) begin
                slot.gain <= wr_value;
            end
            if (wr_offset) begin
                slot.offset <= wr_value;
            end
        end
    end

    // clear value and its per-channel enable
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            slot.clear_value <= CLEAR_VALUE_RST;
            slot.clear_enable <= 1'b0;
        end else begin
            if (wr_clear_value) begin
                slot.clear_value <= wr_value;
            end
            if (wr_clear_enable) begin
                slot.clear_enable <= wr_value[DC_CLEAR_ENABLE];
            end
        end
    end
endmodule

// File: design/qdr_register_decode.sv
// register decode for a four-channel current-output converter, fed by a 24-bit serial frame
// assumes sclk, sync_n, sdin, clear_pin and the straps are asynchronous pins sampled on mclk
//
// Notes on behaviour
// - each channel keeps a 16-bit gain word; select 010 writes one channel.
// - select 011 writes the gain value into all four channels.
// - gain is straight binary 0..65535 and resets to all ones.
// - each channel keeps a 16-bit offset word; select 100 writes one channel.
// - select 101 writes the offset value into all four channels.
// - offset midscale means no adjustment; resets to midscale.
// - per-channel clear value, written by select 110, resets to zero.
// - clear pin loads clear value only into channels with clear enabled.
// - select 111 uses data bits 15..13 as control selector.
// - selector 000 slew, 001 main, 010 dac control, 011 boost, 100 software.
// - control frames share the top-byte layout of data frames.
// - main bit 11 enables status readback during writes; resets off.
// - main bits 9..8 pick timeout 5, 10, 100 or 200 ms.
// - main bit 5 enables all outputs; host must not mix with per-channel.
// - main bit 4 powers up all boost converters together.
// - frames act only when device address matches the strap pins.
// - select 000 writes the addressed channel's data word.
`timescale 1ns/1ps
module qdr_register_decode
    import qdr_pkg::*;
#(
    parameter int WD_CYC_0 = WD_T0_CYC,
    parameter int WD_CYC_1 = WD_T1_CYC,
    parameter int WD_CYC_2 = WD_T2_CYC,
    parameter int WD_CYC_3 = WD_T3_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic clear_pin,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    output logic sdo,
    output qdr_chan_t [CHANS-1:0] chan_regs,
    output qdr_main_t main_ctrl,
    output logic watchdog_alarm,
    output logic frame_accepted
);
    logic sclk_lvl;
    logic sync_n_lvl;
    logic sdin_lvl;
    logic clear_lvl;
    logic [1:0] strap_lvl;
    logic sclk_prev;
    logic sync_prev;
    logic clear_prev;
    logic sclk_fall;
    logic sclk_rise;
    logic sync_fall;
    logic sync_rise;
    logic clear_evt;
    qdr_link_state_t link_state;
    logic [FRAME_BITS-1:0] shift_in;
    logic [CNT_W-1:0] bit_count;
    logic [FRAME_BITS-1:0] shift_out;
    qdr_frame_t frame;
    logic frame_ok;
    logic [2:0] csel;
    logic ctrl_frame;
    logic [CHANS-1:0] ch_hit;
    logic [CHANS-1:0] wr_data_v;
    logic [CHANS-1:0] wr_gain_v;
    logic [CHANS-1:0] wr_offset_v;
    logic [CHANS-1:0] wr_clear_v;
    logic [CHANS-1:0] wr_clren_v;
    logic [WD_W-1:0] wd_count;
    logic [WD_W-1:0] wd_limit;
    logic [FRAME_BITS-1:0] status_word;

    // pin synchronisers; strap pins are treated like any other pin
    qdr_pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_sclk (
        .mclk(mclk), .sys_rst(sys_rst), .pin(sclk), .level(sclk_lvl));
    qdr_pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_frame (
        .mclk(mclk), .sys_rst(sys_rst), .pin(sync_n), .level(sync_n_lvl));
    qdr_pin_sync #(.W(1), .RST_VAL(1'b0)) u_sync_sdin (
        .mclk(mclk), .sys_rst(sys_rst), .pin(sdin), .level(sdin_lvl));
    qdr_pin_sync #(.W(1), .RST_VAL(1'b0)) u_sync_clear (
        .mclk(mclk), .sys_rst(sys_rst), .pin(clear_pin), .level(clear_lvl));
    qdr_pin_sync #(.W(2), .RST_VAL(2'h0)) u_sync_strap (
        .mclk(mclk), .sys_rst(sys_rst), .pin({addr_strap_hi, addr_strap_lo}), .level(strap_lvl));

    // edge history of the filtered levels
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev <= 1'b1; // sclk idles high, so no false edge after reset
            sync_prev <= 1'b1;
            clear_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_lvl;
            sync_prev <= sync_n_lvl;
            clear_prev <= clear_lvl;
        end
    end

    assign sclk_fall = sclk_prev && !sclk_lvl;
    assign sclk_rise = !sclk_prev && sclk_lvl;
    assign sync_fall = sync_prev && !sync_n_lvl;
    assign sync_rise = !sync_prev && sync_n_lvl;
    assign clear_evt = !clear_prev && clear_lvl;

    // frame shifter: data taken on falling sclk while the frame strobe is low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_state <= LK_IDLE;
            shift_in <= '0;
            bit_count <= '0;
        end else begin
            case (link_state)
                LK_IDLE: begin
                    if (sync_fall) begin
                        link_state <= LK_SHIFT;
                        bit_count <= '0;
                    end
                end
                LK_SHIFT: begin
                    if (sync_rise) begin
                        link_state <= LK_IDLE;
                    end else if (sclk_fall) begin
                        shift_in <= {shift_in[FRAME_BITS-2:0], sdin_lvl};
                        // saturate so an overlong frame is never mistaken for a good one
                        if (bit_count <= FRAME_LEN) begin
                            bit_count <= bit_count + 5'h01;
                        end
                    end
                end
                default: begin
                    link_state <= LK_IDLE;
                end
            endcase
        end
    end

    // a frame counts only with exactly 24 bits, a write flag and a matching address
    assign frame = qdr_frame_t'(shift_in);
    assign frame_ok = (link_state == LK_SHIFT) && sync_rise && (bit_count == FRAME_LEN)
        && !frame.rw && (frame.device_addr == strap_lvl);
    assign csel = frame.data[CSEL_HI:CSEL_LO];
    assign ctrl_frame = frame_ok && (frame.register_select == SEL_CONTROL);

    // per-channel write strobes from the register select and channel select
    always_comb begin
        ch_hit = '0;
        ch_hit[frame.channel_sel] = 1'b1;
        wr_data_v = '0;
        wr_gain_v = '0;
        wr_offset_v = '0;
        wr_clear_v = '0;
        wr_clren_v = '0;
        if (frame_ok) begin
            case (frame.register_select)
                SEL_DAC_DATA: wr_data_v = ch_hit;
                SEL_GAIN: wr_gain_v = ch_hit;
                SEL_GAIN_ALL: wr_gain_v = '1;
                SEL_OFFSET: wr_offset_v = ch_hit;
                SEL_OFFSET_ALL: wr_offset_v = '1;
                SEL_CLEAR_VALUE: wr_clear_v = ch_hit;
                SEL_CONTROL: begin
                    // only the clear-enable bit of the channel control is kept here
                    if (csel == CSEL_DAC_CTRL) begin
                        wr_clren_v = ch_hit;
                    end
                end
                default: begin
                    wr_data_v = '0;
                end
            endcase
        end
    end

    // channel storage, one slot per channel
    for (genvar c = 0; c < CHANS; c++) begin : g_chan
        qdr_chan_slot u_slot (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .wr_value(frame.data),
            .wr_dac_data(wr_data_v[c]),
            .wr_gain(wr_gain_v[c]),
            .wr_offset(wr_offset_v[c]),
            .wr_clear_value(wr_clear_v[c]),
            .wr_clear_enable(wr_clren_v[c]),
            .clear_evt(clear_evt),
            .slot(chan_regs[c])
        );
    end

    // main control; slew, boost and software selectors are accepted but hold nothing here
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            main_ctrl <= '0;
        end else if (ctrl_frame) begin
            case (csel)
                CSEL_MAIN: begin
                    main_ctrl.status_readback_enable <= frame.data[MC_STATUS_READ];
                    main_ctrl.watchdog_enable <= frame.data[MC_WD_ENABLE];
                    main_ctrl.watchdog_period <= {frame.data[MC_WD_PERIOD_HI],
                        frame.data[MC_WD_PERIOD_LO]};
                    main_ctrl.global_output_enable <= frame.data[MC_OUTPUT_ALL];
                    main_ctrl.global_boost_power_up <= frame.data[MC_BOOST_ALL];
                end
                CSEL_SLEW, CSEL_DAC_CTRL, CSEL_BOOST, CSEL_SOFTWARE: begin
                    main_ctrl <= main_ctrl;
                end
                default: begin
                    main_ctrl <= main_ctrl;
                end
            endcase
        end
    end

    // watchdog limit from the period select
    always_comb begin
        case (main_ctrl.watchdog_period)
            2'h0: wd_limit = WD_W'(WD_CYC_0);
            2'h1: wd_limit = WD_W'(WD_CYC_1);
            2'h2: wd_limit = WD_W'(WD_CYC_2);
            default: wd_limit = WD_W'(WD_CYC_3);
        endcase
    end

    // activity watchdog: any accepted frame restarts it; alarm holds until the next frame
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wd_count <= '0;
            watchdog_alarm <= 1'b0;
        end else if (!main_ctrl.watchdog_enable || frame_ok) begin
            wd_count <= '0;
            watchdog_alarm <= 1'b0;
        end else if (wd_count >= wd_limit - WD_W'(1)) begin
            watchdog_alarm <= 1'b1;
        end else begin
            wd_count <= wd_count + WD_W'(1);
        end
    end

    // status word returned during the next write frame
    assign status_word = {8'h00, watchdog_alarm, 3'h0, chan_regs[3].clear_enable,
        chan_regs[2].clear_enable, chan_regs[1].clear_enable, chan_regs[0].clear_enable,
        2'h0, main_ctrl.global_output_enable, main_ctrl.global_boost_power_up, 4'h0};

    // readback shifter: loaded at frame start, shifted on rising sclk, quiet when disabled
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_out <= '0;
            sdo <= 1'b0;
        end else if (link_state == LK_IDLE && sync_fall) begin
            shift_out <= main_ctrl.status_readback_enable ? status_word : '0;
            sdo <= 1'b0;
        end else if (link_state == LK_SHIFT && sclk_rise) begin
            sdo <= shift_out[FRAME_BITS-1];
            shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
        end else if (link_state == LK_IDLE) begin
            sdo <= 1'b0;
        end
    end

    // one-cycle pulse per accepted frame
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_accepted <= 1'b0;
        end else begin
            frame_accepted <= frame_ok;
        end
    end
endmodule

// File: verif/qdr_register_decode_sva.sv
// checker for the quad converter register decode, bound to its top module
// assumes the short watchdog counts are handed on by the bind
`timescale 1ns/1ps
module qdr_register_decode_sva
    import qdr_pkg::*;
#(
    parameter int WD_CYC_0 = WD_T0_CYC,
    parameter int WD_CYC_1 = WD_T1_CYC,
    parameter int WD_CYC_2 = WD_T2_CYC,
    parameter int WD_CYC_3 = WD_T3_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic clear_pin,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    input wire logic sdo,
    input wire qdr_chan_t [CHANS-1:0] chan_regs,
    input wire qdr_main_t main_ctrl,
    input wire logic watchdog_alarm,
    input wire logic frame_accepted
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic [63:0] gains, offs, clrs, dacs;
    int lim;
    int idle_cnt;
    logic [3:0] clr_age;
    logic clr_d;

    // flatten per-channel fields for change detection
    always_comb begin
        for (int i = 0; i < CHANS; i++) begin
            gains[16*i+:16] = chan_regs[i].gain;
            offs[16*i+:16] = chan_regs[i].offset;
            clrs[16*i+:16] = chan_regs[i].clear_value;
            dacs[16*i+:16] = chan_regs[i].dac_data;
        end
    end

    // timeout limit for the selected period
    always_comb begin
        case (main_ctrl.watchdog_period)
            2'h0: lim = WD_CYC_0;
            2'h1: lim = WD_CYC_1;
            2'h2: lim = WD_CYC_2;
            default: lim = WD_CYC_3;
        endcase
    end

    // quiet time since the last accepted frame; tolerance covers the pulse lag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_cnt <= 0;
        end else if (frame_accepted || !main_ctrl.watchdog_enable) begin
            idle_cnt <= 0;
        end else begin
            idle_cnt <= idle_cnt + 1;
        end
    end

    // age of the last clear pin rise, saturating
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_d <= 1'b0;
            clr_age <= 4'hf;
        end else begin
            clr_d <= clear_pin;
            if (clear_pin && !clr_d) begin
                clr_age <= 4'h0;
            end else if (clr_age != 4'hf) begin
                clr_age <= clr_age + 4'h1;
            end
        end
    end

    // the accept pulse rises on the same edge as the register write
    sequence s_accept;
        frame_accepted;
    endsequence

    a_gain_write_cause: assert property (!$stable(gains) |-> s_accept)
        else $error("gain changed without an accepted frame");
    a_offset_write_cause: assert property (!$stable(offs) |-> s_accept)
        else $error("offset changed without an accepted frame");
    a_clear_value_cause: assert property (!$stable(clrs) |-> s_accept)
        else $error("clear value changed without an accepted frame");
    a_main_write_cause: assert property (!$stable(main_ctrl) |-> s_accept)
        else $error("main control changed without an accepted frame");
    a_dac_change_cause: assert property (!$stable(dacs) |-> (clr_age <= 4'h8) or s_accept)
        else $error("dac data changed without frame or clear");
    a_gain_reset_value: assert property ($fell(sys_rst) |-> gains == {4{16'hffff}})
        else $error("gain reset value wrong");
    a_offset_reset_value: assert property ($fell(sys_rst) |-> offs == {4{16'h8000}})
        else $error("offset reset value wrong");
    a_sdo_quiet_off: assert property ((!main_ctrl.status_readback_enable)[*8] |-> !sdo)
        else $error("sdo active while readback disabled");
    a_alarm_off_disabled: assert property ((!main_ctrl.watchdog_enable)[*2] |-> !watchdog_alarm)
        else $error("alarm while watchdog disabled");
    a_alarm_rise_time: assert property ($rose(watchdog_alarm) |-> idle_cnt + 3 >= lim && idle_cnt <= lim + 3)
        else $error("alarm raised at wrong time");
    a_alarm_not_late: assert property (main_ctrl.watchdog_enable && idle_cnt == lim + 4 |-> watchdog_alarm)
        else $error("alarm missing after timeout");
endmodule

bind qdr_register_decode qdr_register_decode_sva #(
    .WD_CYC_0(WD_CYC_0), .WD_CYC_1(WD_CYC_1), .WD_CYC_2(WD_CYC_2), .WD_CYC_3(WD_CYC_3)
) sva_u (
    .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .clear_pin(clear_pin), .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo),
    .sdo(sdo), .chan_regs(chan_regs), .main_ctrl(main_ctrl),
    .watchdog_alarm(watchdog_alarm), .frame_accepted(frame_accepted)
);

// File: verif/qdr_host_model.sv
// serial host model: sends write frames on sclk, sync_n and sdin
// assumes a 160 ns link clock; sclk stands high between frames
`timescale 1ns/1ps
module qdr_host_model (
    output logic sclk,
    output logic sync_n,
    output logic sdin
);
    // idle levels at time zero
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end

    // one frame msb first; a count other than 24 is a deliberate fault
    task automatic send(input logic [23:0] f, input int n);
        sync_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            sdin = (k < 24) ? f[23-k] : 1'b0;
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        #80 sync_n = 1'b1;
        sdin = ~sdin; // released line shows no stale level
        // return at once: the accept pulse follows within a few mclk
    endtask
endmodule

// File: verif/qdr_register_decode_bench.sv
// self-checking bench for the quad converter register decode
// assumes the host model drives the link pins and short watchdog counts
`timescale 1ns/1ps
module qdr_register_decode_bench;
    import qdr_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear_pin = 1'b0;
    logic [1:0] strap = 2'b10;
    logic sclk, sync_n, sdin, sdo, watchdog_alarm, frame_accepted;
    qdr_chan_t [CHANS-1:0] chan_regs;
    qdr_main_t main_ctrl;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [23:0] rb = '0;

    qdr_host_model host_u (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));

    qdr_register_decode #(.WD_CYC_0(20), .WD_CYC_1(40), .WD_CYC_2(60), .WD_CYC_3(80)) dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
        .clear_pin(clear_pin), .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]),
        .sdo(sdo), .chan_regs(chan_regs), .main_ctrl(main_ctrl),
        .watchdog_alarm(watchdog_alarm), .frame_accepted(frame_accepted)
    );

    always #4 mclk = ~mclk;

    // readback bits as the host sees them at each rising sclk inside a frame
    always @(posedge sclk) begin
        if (!sync_n) begin
            rb <= {rb[22:0], sdo};
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [23:0] mk(input logic [2:0] s, input logic [1:0] c, input logic [15:0] d);
        return {1'b0, 2'b10, s, c, d};
    endfunction

    // send one frame, then look for the accept pulse for a bounded time
    task automatic fr(input logic [23:0] f, input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        host_u.send(f, n);
        for (int i = 0; i < 16 && !seen; i++) begin
            @(negedge mclk);
            seen = frame_accepted;
        end
        chk({15'h0, seen}, {15'h0, exp});
    endtask

    task automatic t_reset;
        for (int i = 0; i < CHANS; i++) begin
            chk(chan_regs[i].gain, 16'hffff);
            chk(chan_regs[i].offset, 16'h8000);
            chk(chan_regs[i].clear_value, 16'h0000);
        end
        chk({10'h0, main_ctrl}, 16'h0000);
        chk({14'h0, sdo, watchdog_alarm}, 16'h0000);
    endtask

    task automatic t_gain;
        fr(mk(3'h2, 2'h2, 16'h1234), 24, 1'b1);
        for (int i = 0; i < CHANS; i++) chk(chan_regs[i].gain, (i == 2) ? 16'h1234 : 16'hffff);
        fr(mk(3'h3, 2'h1, 16'h0000), 24, 1'b1);
        for (int i = 0; i < CHANS; i++) chk(chan_regs[i].gain, 16'h0000);
    endtask

    task automatic t_offset;
        fr(mk(3'h4, 2'h1, 16'h0001), 24, 1'b1);
        for (int i = 0; i < CHANS; i++) chk(chan_regs[i].offset, (i == 1) ? 16'h0001 : 16'h8000);
        fr(mk(3'h5, 2'h0, 16'h7fff), 24, 1'b1);
        for (int i = 0; i < CHANS; i++) chk(chan_regs[i].offset, 16'h7fff);
    endtask

    // refused frames and unassigned selectors leave storage alone
    task automatic t_refuse;
        fr({1'b0, 2'b01, 3'h2, 2'h0, 16'h0bad}, 24, 1'b0);
        fr({1'b1, 2'b10, 3'h2, 2'h0, 16'h0bad}, 24, 1'b0);
        fr(mk(3'h2, 2'h0, 16'h0bad), 23, 1'b0);
        fr(mk(3'h2, 2'h0, 16'h0bad), 25, 1'b0);
        fr(mk(3'h7, 2'h0, 16'ha080), 24, 1'b1);
        fr(mk(3'h7, 2'h0, 16'he080), 24, 1'b1);
        chk(chan_regs[0].gain, 16'h0000);
        chk({15'h0, chan_regs[0].clear_enable}, 16'h0000);
        chk({10'h0, main_ctrl}, 16'h0000);
        @(posedge mclk);
        strap <= 2'b01;
        repeat (8) @(posedge mclk);
        fr({1'b0, 2'b01, 3'h2, 2'h3, 16'h0bad}, 24, 1'b1);
        chk(chan_regs[3].gain, 16'h0bad);
        @(posedge mclk);
        strap <= 2'b10;
        repeat (8) @(posedge mclk);
    endtask

    task automatic t_clear;
        fr(mk(3'h6, 2'h3, 16'h5a5a), 24, 1'b1);
        fr(mk(3'h6, 2'h0, 16'h1111), 24, 1'b1);
        fr(mk(3'h0, 2'h3, 16'h0f0f), 24, 1'b1);
        fr(mk(3'h0, 2'h0, 16'h2222), 24, 1'b1);
        fr(mk(3'h7, 2'h3, 16'h4080), 24, 1'b1);
        chk(chan_regs[3].clear_value, 16'h5a5a);
        chk(chan_regs[0].clear_value, 16'h1111);
        chk(chan_regs[3].dac_data, 16'h0f0f);
        chk({15'h0, chan_regs[3].clear_enable}, 16'h0001);
        @(posedge mclk);
        clear_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        clear_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(chan_regs[3].dac_data, 16'h5a5a);
        chk(chan_regs[0].dac_data, 16'h2222);
    endtask

    // outputs are dropped before the boost converters go down
    task automatic t_main;
        fr(mk(3'h7, 2'h0, 16'h2b30), 24, 1'b1);
        chk({10'h0, main_ctrl}, 16'h002f);
        fr(mk(3'h7, 2'h0, 16'h2310), 24, 1'b1);
        chk({10'h0, main_ctrl}, 16'h000d);
        chk(rb[15:0], 16'h0830 >> 1);
        fr(mk(3'h7, 2'h0, 16'h2000), 24, 1'b1);
        chk({10'h0, main_ctrl}, 16'h0000);
        chk(rb[15:0], 16'h0000);
    endtask

    task automatic t_wdog;
        for (int p = 0; p < 4; p++) begin
            fr(mk(3'h7, 2'h0, 16'h2400 | (16'(p) << 8)), 24, 1'b1);
            repeat (20 * p + 12) @(negedge mclk);
            chk({15'h0, watchdog_alarm}, 16'h0000);
            repeat (16) @(negedge mclk);
            chk({15'h0, watchdog_alarm}, 16'h0001);
        end
        fr(mk(3'h7, 2'h0, 16'h2000), 24, 1'b1);
        chk({15'h0, watchdog_alarm}, 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_reset();
        t_gain();
        t_offset();
        t_refuse();
        t_clear();
        t_main();
        t_wdog();
        end_of_test();
    end
endmodule
